//--- aci_pkg.sv
package aci_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ERR_FEAT = 8'h01;
  localparam logic [7:0] IDX_SCNT = 8'h02;
  localparam logic [7:0] IDX_SNUM = 8'h03;
  localparam logic [7:0] IDX_CYL_L = 8'h04;
  localparam logic [7:0] IDX_CYL_H = 8'h05;
  localparam logic [7:0] IDX_DRV_HEAD = 8'h06;
  localparam logic [7:0] IDX_STAT_CMD = 8'h07;
  localparam logic [7:0] IDX_ALT_CTL = 8'h0E;
  localparam logic [7:0] IDX_DRV_ADDR = 8'h0F;
  localparam logic [7:0] IDX_CFG = 8'h10;
  // status bits
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DWF = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // drive/head fields
  localparam int ADDR_MODE = 6;
  localparam int DRV_SEL = 4;
  localparam logic [7:0] DRV_HEAD_FIXED = 8'hA0;
  // device control fields
  localparam int CTL_SRST = 2;
  localparam int CTL_NIEN = 1;
  // config fields
  localparam int CFG_IDE = 0;
  localparam int CFG_CARD = 1;
  localparam int CFG_CODE_LO = 4;
  // result codes and the erase command code
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_SLAVE = 8'h80;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] PM_STANDBY = 8'h00;
  localparam logic [7:0] PM_IDLE = 8'hFF;
  localparam logic [7:0] CMD_ERASE = 8'hC0;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int BSY_SET_NS = 400;
  localparam int BSY_SET_CYC = BSY_SET_NS * CLK_MHZ / 1000;
  localparam int DRQ2_US = 700;
  localparam int DRQ2_CYC = DRQ2_US * CLK_MHZ;
  localparam int DRQ3_MS = 20;
  localparam int DRQ3_CYC = DRQ3_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 23;
  typedef enum logic [3:0] {
    K_SIMPLE, K_READ, K_MEDIA, K_POWER, K_DIAG, K_INIT, K_WR2, K_WR3, K_BAD
  } aci_kind_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_MEDIA = 4'b0010,
    S_BUF = 4'b0100,
    S_REL = 4'b1000
  } aci_state_type;
endpackage

//--- aci_dec_if.sv
`timescale 1ns/10ps
interface aci_dec_if;
  logic [7:0] cmd;
  logic [1:0] cls;
  aci_pkg::aci_kind_type kind;
  logic head_used;
  modport dec (input cmd, output cls, output kind, output head_used);
  modport user (output cmd, input cls, input kind, input head_used);
endinterface

//--- aci_decoder.sv
`timescale 1ns/10ps
module aci_decoder (
  aci_dec_if.dec d
);
  ////////////////////////////////////////////////////////////////////////
  // command code to class, kind and head usage
  always_comb
  begin
    d.cls = 2'd1;
    d.kind = aci_pkg::K_BAD;
    d.head_used = 1'b0;
    casez (d.cmd)
      8'h91:
      begin
        d.kind = aci_pkg::K_INIT;
        d.head_used = 1'b1;
      end
      8'hC5, 8'hCD, 8'h3C:
      begin
        d.cls = 2'd3;
        d.kind = aci_pkg::K_WR3;
        d.head_used = 1'b1;
      end
      8'h30, 8'h31, 8'h38, 8'hCA:
      begin
        d.cls = 2'd2;
        d.kind = aci_pkg::K_WR2;
        d.head_used = 1'b1;
      end
      8'hE8:
      begin
        d.cls = 2'd2;
        d.kind = aci_pkg::K_WR2;
      end
      8'h40, 8'h41, 8'hC0, 8'hF5:
      begin
        d.kind = aci_pkg::K_MEDIA;
        d.head_used = 1'b1;
      end
      8'h20, 8'h21, 8'hC4, 8'hC8, 8'h87:
      begin
        d.kind = aci_pkg::K_READ;
        d.head_used = 1'b1;
      end
      8'hEC, 8'hE4: d.kind = aci_pkg::K_READ;
      8'h98, 8'hE5: d.kind = aci_pkg::K_POWER;
      8'h90: d.kind = aci_pkg::K_DIAG;
      8'h7?:
      begin
        d.kind = aci_pkg::K_SIMPLE;
        d.head_used = 1'b1;
      end
      // legacy and power codes finish with no media action
      8'h1?, 8'h00, 8'h03, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE6, 8'hEF, 8'hC6,
      8'h94, 8'h95, 8'h96, 8'h97, 8'h99: d.kind = aci_pkg::K_SIMPLE;
      default: d.kind = aci_pkg::K_BAD;
    endcase
  end
endmodule

//--- aci_top.sv
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
module aci_top #(
  parameter int DRQ2_LIMIT = aci_pkg::DRQ2_CYC,
  parameter int DRQ3_LIMIT = aci_pkg::DRQ3_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pm_not_idle,
  input wire logic buf_ready,
  input wire logic media_done,
  input wire logic media_fault,
  input wire logic [27:0] media_fail_addr,
  input wire logic slave_fail_pin,
  output logic intrq,
  output logic buf_prep,
  output logic media_start,
  output logic [7:0] cmd_code,
  output logic [27:0] cmd_addr,
  output logic cmd_lba_mode,
  output logic [7:0] cmd_count,
  output logic [3:0] geom_heads,
  output logic [7:0] geom_spt
);
  typedef struct packed {
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] cyl_l;
    logic [7:0] cyl_h;
    logic [7:0] drv_head;
    logic [7:0] err;
    logic bsy;
    logic drq;
    logic dwf;
    logic errb;
    logic irq;
    logic intrq;
    logic nien;
    logic srst;
    logic [7:0] cfg;
    logic [2:0] sync;
    logic slave_fail;
    aci_pkg::aci_state_type state;
    aci_pkg::aci_kind_type kind;
    logic [1:0] cls;
    logic [aci_pkg::CNT_W-1:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic buf_prep;
    logic media_start;
    logic [7:0] cmd;
    logic [27:0] addr;
    logic linear_block_mode;
    logic [3:0] heads;
    logic [7:0] spt;
  } aci_regs_type;

  aci_regs_type q;
  aci_regs_type d;
  aci_dec_if dif ();
  logic [7:0] idx;
  logic xfer;
  logic [7:0] status;

  aci_decoder u_dec (
    .d(dif.dec)
  );

  assign idx = paddr[9:2];
  assign xfer = psel && penable && q.pready;
  assign dif.cmd = pwdata[7:0];
  assign status = {q.bsy, !q.bsy, q.dwf, !q.bsy, q.drq, 1'b0, 1'b0, q.errb};

  ////////////////////////////////////////////////////////////////////////
  // next state: bus slave, then command engine; sets come after clears, soft reset clears last
  always_comb
  begin
    logic [7:0] rd;
    logic mapped;
    rd = 8'h00;
    mapped = 1'b1;
    d = q;
    d.buf_prep = 1'b0;
    d.media_start = 1'b0;
    // pin synchroniser; a change counts when the two later stages agree
    d.sync = {q.sync[1:0], slave_fail_pin};
    if (q.sync[1] == q.sync[2])
    begin
      d.slave_fail = q.sync[2];
    end
    // read mux prepared in the cycle that raises pready
    case (idx)
      aci_pkg::IDX_ERR_FEAT: rd = q.err;
      aci_pkg::IDX_SCNT: rd = q.scnt;
      aci_pkg::IDX_SNUM: rd = q.snum;
      aci_pkg::IDX_CYL_L: rd = q.cyl_l;
      aci_pkg::IDX_CYL_H: rd = q.cyl_h;
      aci_pkg::IDX_DRV_HEAD: rd = q.drv_head;
      aci_pkg::IDX_STAT_CMD, aci_pkg::IDX_ALT_CTL: rd = status;
      aci_pkg::IDX_DRV_ADDR: rd = {1'b1, !(q.kind inside {aci_pkg::K_WR2, aci_pkg::K_WR3} && q.bsy),
        ~q.drv_head[3:0], !(q.cfg[aci_pkg::CFG_CARD] && q.drv_head[aci_pkg::DRV_SEL] == q.cfg[aci_pkg::CFG_CARD]),
        !(!q.cfg[aci_pkg::CFG_CARD] && q.drv_head[aci_pkg::DRV_SEL] == q.cfg[aci_pkg::CFG_CARD])};
      aci_pkg::IDX_CFG: rd = q.cfg;
      default: mapped = 1'b0;
    endcase
    if (|paddr[31:10] || |paddr[1:0])
    begin
      mapped = 1'b0;
    end
    // one wait state; pready falls right after each transfer
    d.pready = psel && penable && !q.pready;
    d.pslverr = d.pready && !mapped;
    d.prdata = d.pready && mapped && !pwrite ? {24'h00_0000, rd} : 32'h0000_0000;
    // status read clears a pending interrupt, alternate read leaves it
    if (xfer && !pwrite && idx == aci_pkg::IDX_STAT_CMD)
    begin
      d.irq = 1'b0;
    end
    if (xfer && pwrite)
    begin
      // parameter registers are locked while busy; control stays writable
      case (idx)
        aci_pkg::IDX_ERR_FEAT: if (!q.bsy) d.feat = pwdata[7:0];
        aci_pkg::IDX_SCNT: if (!q.bsy) d.scnt = pwdata[7:0];
        aci_pkg::IDX_SNUM: if (!q.bsy) d.snum = pwdata[7:0];
        aci_pkg::IDX_CYL_L: if (!q.bsy) d.cyl_l = pwdata[7:0];
        aci_pkg::IDX_CYL_H: if (!q.bsy) d.cyl_h = pwdata[7:0];
        aci_pkg::IDX_DRV_HEAD: if (!q.bsy) d.drv_head = pwdata[7:0] | aci_pkg::DRV_HEAD_FIXED;
        aci_pkg::IDX_ALT_CTL:
        begin
          d.nien = pwdata[aci_pkg::CTL_NIEN];
          d.srst = pwdata[aci_pkg::CTL_SRST];
        end
        aci_pkg::IDX_CFG: d.cfg = pwdata[7:0];
        default: d.cfg = q.cfg;
      endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // command engine
    case (q.state)
      aci_pkg::S_IDLE:
      begin
        // a command written while busy is dropped by design
        if (xfer && pwrite && idx == aci_pkg::IDX_STAT_CMD && !q.bsy && !q.srst)
        begin
          d.cmd = pwdata[7:0];
          d.kind = dif.kind;
          d.cls = dif.cls;
          d.linear_block_mode = q.drv_head[aci_pkg::ADDR_MODE];
          // drive-only commands see a zero head field
          d.addr = {dif.head_used ? q.drv_head[3:0] : 4'h0, q.cyl_h, q.cyl_l, q.snum};
          d.errb = 1'b0;
          d.drq = 1'b0;
          d.dwf = 1'b0;
          d.bsy = 1'b1;
          d.state = aci_pkg::S_REL;
          d.cnt = '0;
          case (dif.kind)
            aci_pkg::K_INIT:
            begin
              d.spt = q.scnt;
              d.heads = q.drv_head[3:0];
            end
            aci_pkg::K_POWER: d.scnt = pm_not_idle ? aci_pkg::PM_STANDBY : aci_pkg::PM_IDLE;
            aci_pkg::K_BAD:
            begin
              d.err = aci_pkg::ERR_ABORT;
              d.errb = 1'b1;
            end
            aci_pkg::K_DIAG:
            begin
              if (!q.cfg[aci_pkg::CFG_IDE] && q.drv_head[aci_pkg::DRV_SEL] != q.cfg[aci_pkg::CFG_CARD])
              begin
                d.bsy = 1'b0;
                d.state = aci_pkg::S_IDLE;
              end
              else if (q.cfg[aci_pkg::CFG_IDE] && !q.cfg[aci_pkg::CFG_CARD] && q.slave_fail)
              begin
                d.err = aci_pkg::DIAG_SLAVE | {5'h00, q.cfg[aci_pkg::CFG_CODE_LO +: 3]};
              end
              else
              begin
                d.err = {5'h00, q.cfg[aci_pkg::CFG_CODE_LO +: 3]};
              end
            end
            aci_pkg::K_READ, aci_pkg::K_MEDIA:
            begin
              d.media_start = 1'b1;
              d.state = aci_pkg::S_MEDIA;
            end
            aci_pkg::K_WR2, aci_pkg::K_WR3:
            begin
              d.buf_prep = 1'b1;
              d.state = aci_pkg::S_BUF;
            end
            default: d.state = aci_pkg::S_REL;
          endcase
        end
      end
      aci_pkg::S_MEDIA:
      begin
        if (media_done)
        begin
          d.state = aci_pkg::S_REL;
          if (media_fault)
          begin
            // leave the first failing sector where the host looks for it
            d.errb = 1'b1;
            d.dwf = q.cmd == aci_pkg::CMD_ERASE;
            d.snum = media_fail_addr[7:0];
            d.cyl_l = media_fail_addr[15:8];
            d.cyl_h = media_fail_addr[23:16];
            d.drv_head = {q.drv_head[7:4], media_fail_addr[27:24]};
          end
          else if (q.kind == aci_pkg::K_READ)
          begin
            d.drq = 1'b1;
          end
        end
      end
      aci_pkg::S_BUF:
      begin
        d.cnt = q.cnt + 1'b1;
        // deadline forces the request even if the buffer lags
        if (buf_ready ||
            (q.cls == 2'd2 && q.cnt == aci_pkg::CNT_W'(DRQ2_LIMIT - 1)) ||
            (q.cls == 2'd3 && q.cnt == aci_pkg::CNT_W'(DRQ3_LIMIT - 1)))
        begin
          d.drq = 1'b1;
          d.state = aci_pkg::S_REL;
        end
      end
      aci_pkg::S_REL:
      begin
        d.bsy = 1'b0;
        d.irq = !q.nien;
        d.state = aci_pkg::S_IDLE;
      end
      default: d.state = aci_pkg::S_IDLE;
    endcase
    // soft reset clears status and leaves the passing diagnostic code
    if (d.srst)
    begin
      d.state = aci_pkg::S_IDLE;
      d.bsy = 1'b0;
      d.drq = 1'b0;
      d.dwf = 1'b0;
      d.errb = 1'b0;
      d.irq = 1'b0;
      d.err = aci_pkg::DIAG_OK;
    end
    d.intrq = d.irq && !d.nien;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '{drv_head: aci_pkg::DRV_HEAD_FIXED, err: aci_pkg::DIAG_OK, state: aci_pkg::S_IDLE,
             kind: aci_pkg::K_SIMPLE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign intrq = q.intrq;
  assign buf_prep = q.buf_prep;
  assign media_start = q.media_start;
  assign cmd_code = q.cmd;
  assign cmd_addr = q.addr;
  assign cmd_lba_mode = q.linear_block_mode;
  assign cmd_count = q.scnt;
  assign geom_heads = q.heads;
  assign geom_spt = q.spt;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic cmd_go;
  assign cmd_go = xfer && pwrite && idx == aci_pkg::IDX_STAT_CMD && !q.bsy && !q.srst;

  busy_on_cmd_a: assert property (cmd_go && dif.kind != aci_pkg::K_DIAG |=> q.bsy && q.state != aci_pkg::S_IDLE)
    else $error("busy not raised after command");
  drq2_limit_a: assert property (q.state == aci_pkg::S_BUF && q.cls == 2'd2 |-> q.cnt < DRQ2_LIMIT)
    else $error("class 2 data request late");
  drq3_limit_a: assert property (q.state == aci_pkg::S_BUF && q.cls == 2'd3 |-> q.cnt < DRQ3_LIMIT)
    else $error("class 3 data request late");
  busy_after_drq_a: assert property ($rose(q.drq) && !q.srst |=> !q.bsy)
    else $error("busy held after data request");
  power_query_a: assert property (cmd_go && dif.kind == aci_pkg::K_POWER
      |=> q.scnt == ($past(pm_not_idle) ? 8'h00 : 8'hFF) && q.bsy ##1 !q.bsy || q.srst)
    else $error("power query answer wrong");
  abort_code_a: assert property (cmd_go && dif.kind == aci_pkg::K_BAD |=> q.errb && q.err == 8'h04)
    else $error("unknown command not aborted");
  stat_clear_a: assert property (xfer && !pwrite && idx == aci_pkg::IDX_STAT_CMD
      && q.state == aci_pkg::S_IDLE |=> !q.irq)
    else $error("status read left interrupt");
  alt_keep_a: assert property (xfer && !pwrite && idx == aci_pkg::IDX_ALT_CTL && q.irq
      && q.state == aci_pkg::S_IDLE && !q.srst |=> q.irq)
    else $error("alternate read cleared interrupt");
  diag_skip_a: assert property (cmd_go && dif.kind == aci_pkg::K_DIAG && !q.cfg[aci_pkg::CFG_IDE]
      && q.drv_head[aci_pkg::DRV_SEL] != q.cfg[aci_pkg::CFG_CARD] |=> !q.bsy && $stable(q.err))
    else $error("diagnostic ran on unselected card");
  head_mask_a: assert property (cmd_go && !dif.head_used |=> q.addr[27:24] == 4'h0)
    else $error("head bits used for drive-only command");
endmodule

//--- aci_media_model.sv
`timescale 1ns/10ps
module aci_media_model #(
  parameter logic [27:0] FAIL_ADDR = 28'h0ab_cdef
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic buf_prep,
  input wire logic media_start,
  input wire logic stall,
  input wire logic fault,
  output logic buf_ready,
  output logic media_done,
  output logic media_fault,
  output logic [27:0] media_fail_addr
);
  logic [3:0] bcnt_q;
  logic [3:0] mcnt_q;
  logic tog_q;
  ////////////////////////////////////////////////////////////////
  // buffer ready 4 cycles after prepare, never while stalled, so the deadline path is reachable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bcnt_q <= 4'h0;
      mcnt_q <= 4'h0;
      tog_q <= 1'b0;
    end
    else
    begin
      tog_q <= ~tog_q;
      bcnt_q <= buf_prep ? 4'h4 : (bcnt_q != 4'h0 ? bcnt_q - 4'h1 : 4'h0);
      mcnt_q <= media_start ? 4'h6 : (mcnt_q != 4'h0 ? mcnt_q - 4'h1 : 4'h0);
    end
  end
  // fault and address only hold meaning beside done; otherwise they wander
  assign buf_ready = (bcnt_q == 4'h1) && !stall;
  assign media_done = (mcnt_q == 4'h1);
  assign media_fault = media_done ? fault : tog_q;
  assign media_fail_addr = media_done ? FAIL_ADDR : {28{tog_q}};
endmodule

//--- aci_top_test.sv
`timescale 1ns/10ps
module aci_top_test;
  localparam int D2 = 50;
  localparam int D3 = 80;
  localparam logic [27:0] FA = 28'h0ab_cdef;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pm_not_idle = 1'b0;
  logic stall = 1'b0;
  logic fault = 1'b0;
  logic slave_fail_pin = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic buf_ready;
  logic media_done;
  logic media_fault;
  logic [27:0] media_fail_addr;
  logic intrq;
  logic buf_prep;
  logic media_start;
  logic [7:0] cmd_code;
  logic [27:0] cmd_addr;
  logic cmd_lba_mode;
  logic [7:0] cmd_count;
  logic [3:0] geom_heads;
  logic [7:0] geom_spt;
  logic [31:0] rdv;
  logic slv;
  int err_total = 0;
  int samples_checked = 0;
  int prep_cnt = 0;
  int start_cnt = 0;
  logic [7:0] c;
  int p;
  ////////////////////////////////////////////////////////////////
  aci_top #(.DRQ2_LIMIT(D2), .DRQ3_LIMIT(D3)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_not_idle(pm_not_idle), .buf_ready(buf_ready), .media_done(media_done), .media_fault(media_fault),
    .media_fail_addr(media_fail_addr), .slave_fail_pin(slave_fail_pin), .intrq(intrq), .buf_prep(buf_prep),
    .media_start(media_start), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_lba_mode(cmd_lba_mode),
    .cmd_count(cmd_count), .geom_heads(geom_heads), .geom_spt(geom_spt));
  aci_media_model #(.FAIL_ADDR(FA)) media (.clk(clk), .reset_n(reset_n), .buf_prep(buf_prep),
    .media_start(media_start), .stall(stall), .fault(fault), .buf_ready(buf_ready), .media_done(media_done),
    .media_fault(media_fault), .media_fail_addr(media_fail_addr));
  ////////////////////////////////////////////////////////////////
  // 250 MHz clock; pulse counters let slow apb polling still see one-cycle strobes
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    prep_cnt += (buf_prep === 1'b1);
    start_cnt += (media_start === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    rdv = prdata;
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 20, 1, "pready");
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    xfer(1'b0, idx, 8'h00);
    chk(rdv, {24'h0, exp}, what);
  endtask
  // alternate status polling leaves the pending interrupt alone
  task automatic wait_ready;
    int n;
    n = 0;
    rdv = 32'h0000_0080;
    while (rdv[7] !== 1'b0 && n < 300)
    begin
      xfer(1'b0, 8'h0E, 8'h00);
      n++;
    end
    chk(n < 300, 1, "busy stuck");
  endtask
  // command goes last, after parameters, and only once busy is clear
  task automatic cmd(input logic [7:0] code);
    wait_ready;
    xfer(1'b1, 8'h07, code);
    wait_ready;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog sized well past the whole sequence
  initial
  begin
    #80000;
    err_total++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h07, 8'h50, "status");
    rd(8'h01, 8'h01, "error");
    rd(8'h06, 8'hA0, "drive head");
    xfer(1'b0, 8'h20, 8'h00);
    chk(slv, 1'b1, "unmapped");
    $display("test reset done");
    xfer(1'b1, 8'h06, 8'hAF);
    for (int i = 0; i < 4; i++)
    begin
      pm_not_idle <= i[1];
      xfer(1'b1, 8'h02, 8'h55);
      cmd(i[0] ? 8'h98 : 8'hE5);
      rd(8'h02, i[1] ? 8'h00 : 8'hFF, "power mode");
      chk(cmd_addr[27:24], 4'h0, "head ignored");
      rd(8'h0E, 8'h50, "alt status");
      chk(intrq, 1'b1, "irq kept");
      rd(8'h07, 8'h50, "status");
      // the clear lands at the transfer edge; look once it has settled
      @(posedge clk);
      chk(intrq, 1'b0, "irq cleared");
    end
    xfer(1'b1, 8'h0E, 8'h02);
    cmd(8'hE5);
    chk(intrq, 1'b0, "irq masked");
    xfer(1'b1, 8'h0E, 8'h00);
    rd(8'h07, 8'h50, "status");
    $display("test power query done");
    xfer(1'b1, 8'h02, 8'h3F);
    xfer(1'b1, 8'h06, 8'hA5);
    cmd(8'h91);
    chk({geom_heads, geom_spt}, 12'h53F, "geometry");
    for (int i = 0; i < 5; i++)
    begin
      c = (i == 4) ? 8'hC4 : {i[1] ? 4'h4 : 4'h2, 3'b000, i[0]};
      xfer(1'b1, 8'h02, 8'h04);
      xfer(1'b1, 8'h03, 8'h11);
      xfer(1'b1, 8'h04, 8'h22);
      xfer(1'b1, 8'h05, 8'h33);
      xfer(1'b1, 8'h06, i[0] ? 8'hE7 : 8'hA7);
      p = start_cnt;
      cmd(c);
      chk(start_cnt - p, 1, "media start");
      chk(cmd_code, c, "command code");
      chk({cmd_lba_mode, cmd_count, cmd_addr}, {i[0], 8'h04, 28'h733_2211}, "address");
      chk(intrq, 1'b1, "irq");
      // sector reads leave a data request standing, verify does not
      rd(8'h07, i[1] ? 8'h50 : 8'h58, "status");
    end
    $display("test read class done");
    for (int i = 0; i < 9; i++)
    begin
      case (i)
        0: c = 8'h30;
        1: c = 8'h31;
        2: c = 8'h38;
        3: c = 8'hE8;
        4: c = 8'hC5;
        5: c = 8'hCD;
        6: c = 8'h3C;
        7: c = 8'h30;
        default: c = 8'h3C;
      endcase
      stall <= (i > 6);
      p = prep_cnt;
      wait_ready;
      xfer(1'b1, 8'h07, c);
      if (i > 6)
      begin
        repeat (D2 - 30) @(posedge clk);
        rd(8'h0E, 8'h80, "busy before deadline");
      end
      wait_ready;
      chk(prep_cnt - p, 1, "buffer prepare");
      rd(8'h07, 8'h58, "data request");
    end
    stall <= 1'b0;
    $display("test write class done");
    cmd(8'hF0);
    rd(8'h07, 8'h51, "abort status");
    rd(8'h01, 8'h04, "abort code");
    // soft reset restores the passing code and drops commands until released
    xfer(1'b1, 8'h0E, 8'h04);
    xfer(1'b1, 8'h07, 8'hF0);
    rd(8'h01, 8'h01, "soft reset code");
    rd(8'h07, 8'h50, "soft reset status");
    xfer(1'b1, 8'h0E, 8'h00);
    cmd(8'h00);
    rd(8'h07, 8'h50, "nop status");
    fault <= 1'b1;
    p = prep_cnt;
    c = 8'hC0;
    cmd(c);
    chk(prep_cnt - p, 0, "no transfer");
    rd(8'h07, 8'h71, "write fault");
    rd(8'h03, FA[7:0], "fail addr low");
    rd(8'h05, FA[23:16], "fail addr high");
    fault <= 1'b0;
    $display("test erase done");
    xfer(1'b1, 8'h06, 8'hA0);
    xfer(1'b1, 8'h10, 8'h10);
    cmd(8'h90);
    rd(8'h01, 8'h01, "diag selected");
    rd(8'h07, 8'h50, "diag status");
    xfer(1'b1, 8'h10, 8'h30);
    xfer(1'b1, 8'h06, 8'hB0);
    cmd(8'h90);
    chk(intrq, 1'b0, "diag other card");
    rd(8'h01, 8'h01, "diag skipped");
    for (int k = 1; k < 6; k++)
    begin
      slave_fail_pin <= (k == 5);
      xfer(1'b1, 8'h10, {1'b0, k[2:0], 4'h1});
      repeat (4) @(posedge clk);
      cmd(8'h90);
      rd(8'h01, {(k == 5), 4'h0, k[2:0]}, "diag code");
    end
    $display("test diagnostic done");
    stop_test;
  end
endmodule
